// [hdl/adc_seq_cfg.svh]
// Constants for the converter link: configuration word layout,
// sequencer codes, timing counts and controller register offsets.
// Assumes a 25 MHz aclk; included by the package, both link ends and the bench.
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

// ****************************************
// Configuration word layout
// ****************************************
`define CFG_W              14
`define CFG_UPDATE_BIT     13
`define INPUT_MSB          12
`define INPUT_LSB          10
`define PAIR_SEL_BIT       11
`define LAST_MSB           9
`define LAST_LSB           7
`define BW_BIT             6
`define REF_MSB            5
`define REF_LSB            3
`define SEQ_MSB            2
`define SEQ_LSB            1
`define READBACK_BIT       0
`define CFG_DEFAULT        14'h3fff
`define SEQ_OFF            2'h0
`define SEQ_UPDATE         2'h1
`define SEQ_SCAN_TEMP      2'h2
`define SEQ_SCAN           2'h3
`define DEFAULT_HOLD_CONVS 2
`define RESULT_W           16
`define FRAME_BITS         16

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS      40
`define CONV_TIME_NS       1600
`define CONV_CYCLES        ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POWERUP_TIME_NS    2000
`define POWERUP_CYCLES     ((`POWERUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNV_HIGH_CYCLES    2
`define CONV_WAIT_CYCLES   (`CONV_CYCLES + 4)
`define SCK_HALF_CYCLES    2

// ****************************************
// Controller registers
// ****************************************
`define REG_COMMAND        8'h00
`define REG_CONFIG         8'h04
`define REG_RESULT         8'h08
`define REG_STATUS         8'h0c
`define CMD_CONVERT_BIT    0
`define CMD_WRITE_BIT      1
`define CMD_DEFAULT_BIT    2
`define AXI_OKAY           2'h0
`define AXI_SLVERR         2'h2

`endif

// [hdl/adc_seq_pkg.sv]
// Types shared by both ends of the converter link.
// Assumes the constants header is on the include path.
`include "adc_seq_cfg.svh"

package adc_seq_pkg;
	typedef logic [`CFG_W-1:0]    cfg_word_type;
	typedef logic [`RESULT_W-1:0] result_type;
	typedef enum logic [2:0] {
		host_powerup,
		host_idle,
		host_cnv,
		host_wait,
		host_frame
	} host_state_type;
endpackage

// [hdl/adc_link_if.sv]
// Serial link between controller and converter.
// Assumes both ends run on the same aclk.
`timescale 1ns/100ps

interface adc_link_if;
	logic conversion_start;
	logic sck;
	logic din;
	logic sdo;
	modport device (input conversion_start, input sck, input din, output sdo);
	modport host (output conversion_start, output sck, output din, input sdo);
endinterface

// [hdl/channel_stepper.sv]
// Slot stepper of the converter sequencer.
// Assumes step and restart are one-cycle pulses, never both high.
`timescale 1ns/100ps

module channel_stepper (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       step,
	input  wire logic       restart,
	input  wire logic       seq_on,
	input  wire logic       paired,
	input  wire logic [2:0] last_channel_field,
	input  wire logic       temp_on,
	output logic      [2:0] pos_channel,
	output logic      [2:0] neg_channel,
	output logic            temp_slot
);
	logic [2:0] slot;
	logic       in_temp;
	logic [2:0] final_slot;

	// Pairs always end on an even channel
	assign final_slot = paired ? {last_channel_field[2:1], 1'b0} : last_channel_field; // RL2 RL3

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			slot    <= 3'h0;
			in_temp <= 1'b0;
		end else if (restart) begin
			slot    <= 3'h0; // RL7
			in_temp <= 1'b0;
		end else if (step && seq_on) begin
			if (in_temp) begin
				slot    <= 3'h0; // RL21
				in_temp <= 1'b0;
			end else if (slot >= final_slot) begin
				slot    <= 3'h0; // RL1
				in_temp <= temp_on; // RL8
			end else begin
				slot <= slot + (paired ? 3'h2 : 3'h1); // RL21
			end
		end
	end

	assign pos_channel = seq_on ? slot : final_slot;
	assign neg_channel = pos_channel | {2'h0, paired}; // RL3
	assign temp_slot   = seq_on & in_temp;
endmodule

// [hdl/adc_device_end.sv]
// Converter end of the link: configuration shift-in, sequencer,
// conversion timing, result coding and power control.
// Assumes link pins synchronous to aclk and an analog core that
// returns sample_code and temp_code for the selected input.
//
// Summary of operation
// [RL1] Scan from channel zero to last channel
// [RL2] Pair set follows programmed last channel
// [RL3] Even positive, odd negative, ignore low bit
// [RL4] Host writes sequencer field to start scanning
// [RL5] Host keeps config input low after update
// [RL6] Code 01 updates without breaking scan
// [RL7] Pairing or last change restarts at zero
// [RL8] Singles or pairs, optional temperature slot
// [RL9] Code 10 with singles adds temperature slot
// [RL10] Code 11 pairs scan without temperature slot
// [RL11] Internal reference also enables temperature sensor
// [RL12] Host picks internal reference for temperature
// [RL13] Temperature result always straight binary
// [RL14] Reference and buffer power down independently
// [RL15] Core powers down after each conversion
// [RL16] Host holds start low during power-up
// [RL17] Config shifted MSB first, 14 rising edges
// [RL18] New config governs the following conversion
// [RL19] Top bit set overwrites, clear keeps
// [RL20] Input high two conversions loads all ones
// [RL21] Advance one slot, wrap after final
`timescale 1ns/100ps
`include "adc_seq_cfg.svh"

module adc_device_end
	import adc_seq_pkg::*;
#(
	parameter int CONV_CYCLES = `CONV_CYCLES
)(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	adc_link_if.device       link,
	input  wire result_type  sample_code,
	input  wire result_type  temp_code,
	output logic       [2:0] mux_pos,
	output logic       [2:0] mux_neg,
	output logic             pair_mode,
	output logic             temp_select,
	output logic             ref_enable,
	output logic             buffer_enable,
	output logic             temp_sensor_enable,
	output logic             core_powered,
	output logic             quarter_bandwidth,
	output logic             configured
);

	// ****************************************
	// Decoding helpers
	// ****************************************
	// Returns {reference on, buffer on}
	function automatic logic [1:0] ref_decode(input logic [2:0] code);
		logic ref_on;
		logic buf_on;
		ref_on = ~code[2];
		buf_on = ~(code[2] ^ code[1]);
		return {ref_on, buf_on};
	endfunction

	function automatic logic is_bipolar(input logic [2:0] input_arrangement_field);
		return (input_arrangement_field[2:1] == 2'h0) || (input_arrangement_field == 3'h2);
	endfunction

	function automatic result_type code_for(input result_type raw,
		input logic temp, input logic [2:0] input_arrangement_field);
		result_type code;
		code = raw;
		if (!temp && is_bipolar(input_arrangement_field)) begin
			code = {~raw[15], raw[14:0]};
		end
		return code;
	endfunction

	// ****************************************
	// Signals
	// ****************************************
	logic             sck_prev;
	logic             cnv_prev;
	logic             sck_rise;
	logic             sck_fall;
	logic             cnv_rise;
	logic       [4:0] bit_cnt;
	logic      [12:0] cfg_shift;
	cfg_word_type     new_word;
	logic             word_done;
	cfg_word_type     active_cfg;
	cfg_word_type     pending_cfg;
	cfg_word_type     merged_cfg;
	logic             pending_valid;
	logic       [1:0] high_cnt;
	logic             default_load;
	logic             busy;
	logic      [15:0] conv_cnt;
	logic             conv_temp;
	logic             conv_end;
	logic      [29:0] out_shift;
	logic             restart;
	logic             step;
	logic       [2:0] slot_pos;
	logic       [2:0] slot_neg;
	logic             slot_temp;
	logic       [1:0] seq_field;
	logic       [1:0] new_seq;
	logic       [1:0] ref_bits;

	assign sck_rise  = link.sck & ~sck_prev;
	assign sck_fall  = ~link.sck & sck_prev;
	assign cnv_rise  = link.conversion_start & ~cnv_prev;
	assign conv_end  = busy && (conv_cnt == 16'h0);
	assign seq_field = active_cfg[`SEQ_MSB:`SEQ_LSB];
	assign new_seq   = pending_cfg[`SEQ_MSB:`SEQ_LSB];
	assign ref_bits  = ref_decode(active_cfg[`REF_MSB:`REF_LSB]);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sck_prev <= 1'b0;
			cnv_prev <= 1'b0;
		end else begin
			sck_prev <= link.sck;
			cnv_prev <= link.conversion_start;
		end
	end

	// ****************************************
	// Configuration shift-in
	// ****************************************
	// Only the first 14 rising edges of a frame carry the word
	assign new_word  = {cfg_shift, link.din}; // RL17
	assign word_done = sck_rise && !link.conversion_start && (bit_cnt == 5'd13);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bit_cnt   <= 5'h0;
			cfg_shift <= 13'h0;
		end else if (link.conversion_start) begin
			bit_cnt <= 5'h0;
		end else if (sck_rise && (bit_cnt < 5'd14)) begin
			cfg_shift <= {cfg_shift[11:0], link.din}; // RL17
			bit_cnt   <= bit_cnt + 5'h1;
		end
	end

	// Consecutive conversions started with the input held high
	assign default_load = cnv_rise && !busy && link.din &&
		(high_cnt == 2'(`DEFAULT_HOLD_CONVS - 1)); // RL20

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			high_cnt <= 2'h0;
		end else if (cnv_rise && !busy) begin
			if (!link.din || default_load) begin
				high_cnt <= 2'h0;
			end else begin
				high_cnt <= high_cnt + 2'h1;
			end
		end
	end

	// Clear first so a word landing on the apply edge is kept
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pending_cfg   <= `CFG_DEFAULT;
			pending_valid <= 1'b0;
		end else begin
			if (conv_end) begin
				pending_valid <= 1'b0;
			end
			if (word_done && new_word[`CFG_UPDATE_BIT]) begin
				pending_cfg   <= new_word; // RL19
				pending_valid <= 1'b1;
			end else if (default_load) begin
				pending_cfg   <= `CFG_DEFAULT; // RL20
				pending_valid <= 1'b1;
			end
		end
	end

	// ****************************************
	// Applying a new word
	// ****************************************
	// Code 01 keeps the running sequencer mode
	always_comb begin
		merged_cfg = pending_cfg;
		if (new_seq == `SEQ_UPDATE) begin
			merged_cfg[`SEQ_MSB:`SEQ_LSB] = seq_field; // RL6
		end
	end

	assign restart = conv_end && pending_valid && ((new_seq != `SEQ_UPDATE) || // RL4
		(pending_cfg[`PAIR_SEL_BIT] != active_cfg[`PAIR_SEL_BIT]) ||
		(pending_cfg[`LAST_MSB:`LAST_LSB] != active_cfg[`LAST_MSB:`LAST_LSB])); // RL7
	assign step    = conv_end && !restart; // RL21

	// Word takes effect at end of conversion, so it steers the next one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			active_cfg <= 14'h0;
			configured <= 1'b0;
		end else if (conv_end && pending_valid) begin
			active_cfg <= merged_cfg; // RL18
			configured <= 1'b1;
		end
	end

	channel_stepper u_stepper (
		.aclk               (aclk),
		.aresetn            (aresetn),
		.step               (step),
		.restart            (restart),
		.seq_on             (seq_field[1]), // RL8
		.paired             (~active_cfg[`PAIR_SEL_BIT]),
		.last_channel_field (active_cfg[`LAST_MSB:`LAST_LSB]),
		.temp_on            (seq_field == `SEQ_SCAN_TEMP), // RL9 RL10
		.pos_channel        (slot_pos),
		.neg_channel        (slot_neg),
		.temp_slot          (slot_temp)
	);

	// ****************************************
	// Conversion timing
	// ****************************************
	// Start pulses during a conversion are ignored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy      <= 1'b0;
			conv_cnt  <= 16'h0;
			conv_temp <= 1'b0;
		end else if (cnv_rise && !busy) begin
			busy      <= 1'b1;
			conv_cnt  <= 16'(CONV_CYCLES - 1);
			conv_temp <= slot_temp;
		end else if (conv_end) begin
			busy <= 1'b0; // RL15
		end else if (busy) begin
			conv_cnt <= conv_cnt - 16'h1;
		end
	end

	// ****************************************
	// Result readout
	// ****************************************
	// Result first, then the word it was taken with when readback is on
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_shift <= 30'h0;
		end else if (conv_end) begin
			out_shift <= {code_for(conv_temp ? temp_code : sample_code, conv_temp, // RL13
				active_cfg[`INPUT_MSB:`INPUT_LSB]),
				active_cfg[`READBACK_BIT] ? 14'h0 : active_cfg};
		end else if (sck_fall && !link.conversion_start) begin
			out_shift <= {out_shift[28:0], 1'b0};
		end
	end

	assign link.sdo = out_shift[29];

	// ****************************************
	// Core control outputs
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mux_pos            <= 3'h0;
			mux_neg            <= 3'h0;
			pair_mode          <= 1'b0;
			temp_select        <= 1'b0;
			ref_enable         <= 1'b0;
			buffer_enable      <= 1'b0;
			temp_sensor_enable <= 1'b0;
			core_powered       <= 1'b0;
			quarter_bandwidth  <= 1'b0;
		end else begin
			mux_pos            <= slot_pos; // RL1
			mux_neg            <= slot_neg; // RL3
			pair_mode          <= ~active_cfg[`PAIR_SEL_BIT];
			temp_select        <= slot_temp;
			ref_enable         <= ref_bits[1]; // RL14
			buffer_enable      <= ref_bits[0]; // RL14
			temp_sensor_enable <= ref_bits[1]; // RL11
			core_powered       <= busy; // RL15
			quarter_bandwidth  <= ~active_cfg[`BW_BIT];
		end
	end
endmodule

// [hdl/adc_host_end.sv]
// Controller end of the link: AXI4-Lite register slave and the
// serial sequence that starts conversions and moves words.
// Assumes one aclk shared with the converter end.
`timescale 1ns/100ps
`include "adc_seq_cfg.svh"

module adc_host_end
	import adc_seq_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic  [7:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic  [3:0] wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic       [1:0] bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic  [7:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic      [31:0] rdata,
	output logic       [1:0] rresp,
	output logic             rvalid,
	input  wire logic        rready,
	adc_link_if.host         link
);
	host_state_type state;
	logic     [15:0] cnt;
	logic      [4:0] bit_idx;
	cfg_word_type    cfg_word;
	cfg_word_type    tx;
	result_type      rx;
	result_type      result;
	logic      [1:0] default_left;
	logic            do_write;
	logic            cnv_q;
	logic            sck_q;
	logic            din_q;
	logic            aw_held;
	logic            w_held;
	logic      [7:0] aw_addr;
	logic     [31:0] w_data;
	logic      [3:0] w_strb;
	logic            do_reg_write;
	logic            cmd_go;

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	assign do_reg_write = aw_held && w_held && !bvalid;
	assign cmd_go = do_reg_write && (aw_addr == `REG_COMMAND) && w_strb[0] &&
		(state == host_idle) && (w_data[2:0] != 3'h0);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready  <= 1'b0;
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= `AXI_OKAY;
		end else begin
			awready <= awvalid && !awready && !aw_held;
			wready  <= wvalid && !wready && !w_held;
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				aw_addr <= awaddr;
			end
			if (wvalid && wready) begin
				w_held <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			if (do_reg_write) begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= (aw_addr > `REG_STATUS || aw_addr[1:0] != 2'h0) ?
					`AXI_SLVERR : `AXI_OKAY;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_word <= `CFG_DEFAULT;
		end else if (do_reg_write && aw_addr == `REG_CONFIG) begin
			if (w_strb[0]) begin
				cfg_word[7:0] <= w_data[7:0];
			end
			if (w_strb[1]) begin
				cfg_word[13:8] <= w_data[13:8];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= `AXI_OKAY;
		end else begin
			arready <= arvalid && !arready && !rvalid;
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rresp  <= `AXI_OKAY;
				unique case (araddr)
					`REG_COMMAND: rdata <= 32'h0000_0000;
					`REG_CONFIG:  rdata <= {18'h0, cfg_word};
					`REG_RESULT:  rdata <= {16'h0, result};
					`REG_STATUS:  rdata <= {30'h0, state != host_powerup,
						state != host_idle};
					default: begin
						rdata <= 32'h0000_0000;
						rresp <= `AXI_SLVERR;
					end
				endcase
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// ****************************************
	// Link sequence
	// ****************************************
	// Config input stays low outside the word, except when held high for a default load, so no stray update
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state        <= host_powerup;
			cnt          <= 16'(`POWERUP_CYCLES - 1);
			cnv_q        <= 1'b0;
			sck_q        <= 1'b0;
			din_q        <= 1'b0;
			bit_idx      <= 5'h0;
			tx           <= 14'h0;
			rx           <= 16'h0;
			result       <= 16'h0;
			default_left <= 2'h0;
			do_write     <= 1'b0;
		end else begin
			unique case (state)
				host_powerup: begin
					if (cnt == 16'h0) begin
						state <= host_idle; // RL16
					end else begin
						cnt <= cnt - 16'h1;
					end
				end
				host_idle: begin
					if (cmd_go) begin
						cnv_q        <= 1'b1;
						cnt          <= 16'(`CNV_HIGH_CYCLES - 1);
						state        <= host_cnv;
						do_write     <= w_data[`CMD_WRITE_BIT];
						tx           <= cfg_word;
						default_left <= w_data[`CMD_DEFAULT_BIT] ?
							2'(`DEFAULT_HOLD_CONVS) : 2'h0;
						din_q        <= w_data[`CMD_DEFAULT_BIT]; // RL20
					end
				end
				host_cnv: begin
					if (cnt == 16'h0) begin
						cnv_q <= 1'b0;
						cnt   <= 16'(`CONV_WAIT_CYCLES - 1);
						state <= host_wait;
					end else begin
						cnt <= cnt - 16'h1;
					end
				end
				host_wait: begin
					if (cnt != 16'h0) begin
						cnt <= cnt - 16'h1;
					end else if (default_left > 2'h1) begin
						default_left <= default_left - 2'h1;
						cnv_q        <= 1'b1;
						cnt          <= 16'(`CNV_HIGH_CYCLES - 1);
						state        <= host_cnv;
					end else if (default_left == 2'h1) begin
						default_left <= 2'h0;
						din_q        <= 1'b0;
						state        <= host_idle;
					end else begin
						state   <= host_frame;
						cnt     <= 16'(`SCK_HALF_CYCLES - 1);
						bit_idx <= 5'h0;
						din_q   <= do_write & tx[13]; // RL17
					end
				end
				host_frame: begin
					if (cnt != 16'h0) begin
						cnt <= cnt - 16'h1;
					end else begin
						cnt <= 16'(`SCK_HALF_CYCLES - 1);
						if (!sck_q) begin
							sck_q <= 1'b1;
							rx    <= {rx[14:0], link.sdo};
						end else begin
							sck_q   <= 1'b0;
							tx      <= {tx[12:0], 1'b0};
							bit_idx <= bit_idx + 5'h1;
							din_q   <= do_write && (bit_idx < 5'd13) && tx[12]; // RL5
							if (bit_idx == 5'(`FRAME_BITS - 1)) begin
								state  <= host_idle;
								result <= rx;
								din_q  <= 1'b0;
							end
						end
					end
				end
			endcase
		end
	end

	assign link.conversion_start = cnv_q;
	assign link.sck = sck_q;
	assign link.din = din_q;
endmodule

// [sim/adc_link_chk.sv]
// Checker for the serial wires between the two converter link ends.
// Assumes tb_top instantiates it beside the link interface.
`timescale 1ns/100ps

module adc_link_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic conversion_start,
	input wire logic sck,
	input wire logic din,
	input wire logic sdo
);
	// ********
	// Helper counters
	// ********
	logic [7:0] up_count;
	logic [4:0] pulse_count;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			up_count <= 8'h00;
		end else if (up_count != 8'hff) begin
			up_count <= up_count + 8'h01;
		end
	end

	// Pulses counted per frame, so a short frame shows at the next start
	always_ff @(posedge aclk) begin
		if (!aresetn || $rose(conversion_start)) begin
			pulse_count <= 5'h00;
		end else if ($rose(sck)) begin
			pulse_count <= pulse_count + 5'h01;
		end
	end

	// ********
	// Assertions
	// ********
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_cnv_powerup: assert property (up_count < 8'h31 |-> !conversion_start)
		else $error("conversion start during power-up");
	chk_cnv_pulse: assert property ($rose(conversion_start) |=> conversion_start ##1 !conversion_start)
		else $error("conversion start pulse width wrong");
	chk_quiet_cnv: assert property (conversion_start |-> !sck)
		else $error("serial clock active with start high");
	chk_din_hold: assert property (sck && $past(sck) |-> $stable(din))
		else $error("config data moved while clock high");
	chk_sck_half: assert property ($rose(sck) |-> sck[*2] ##1 !sck)
		else $error("serial clock half period wrong");
	chk_conv_wait: assert property ($fell(conversion_start) |-> !sck[*8])
		else $error("frame began during conversion");
	chk_sdo_hold: assert property (sck && $past(sck) |-> $stable(sdo))
		else $error("result data moved while clock high");
	chk_frame_bits: assert property ($rose(conversion_start) |-> pulse_count == 0 || pulse_count == 16)
		else $error("frame clock count wrong");
	chk_din_tail: assert property ($rose(sck) && pulse_count >= 5'h0e |-> !din)
		else $error("config input high after the word");
endmodule

// [sim/tb_top.sv]
// Bench joining both link ends, with a slot and result model.
// Assumes the design package and constants header are compiled first.
`timescale 1ns/100ps
`include "adc_seq_cfg.svh"

module tb_top
	import adc_seq_pkg::*;
;
	logic         aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic         arvalid, arready, rvalid, rready, cap_temp, cap_on;
	logic         pair_mode, temp_select, ref_enable, buffer_enable;
	logic         temp_sensor_enable, core_powered, quarter_bandwidth, arr_v, val, configured;
	logic [7:0]   awaddr, araddr;
	logic [31:0]  wdata, rdata, d;
	logic [3:0]   wstrb;
	logic [1:0]   bresp, rresp, r;
	logic [2:0]   mux_pos, mux_neg, cap_pos, cap_neg;
	result_type   sample_code, temp_code;
	cfg_word_type act, arr, cfg_reg;
	int           k, fail_count, total_checks;

	adc_link_if link ();
	adc_device_end #(.CONV_CYCLES(4)) adc_device_end_inst (.aclk(aclk), .aresetn(aresetn),
		.link(link.device), .sample_code(sample_code), .temp_code(temp_code),
		.mux_pos(mux_pos), .mux_neg(mux_neg), .pair_mode(pair_mode), .temp_select(temp_select),
		.ref_enable(ref_enable), .buffer_enable(buffer_enable), .configured(configured),
		.temp_sensor_enable(temp_sensor_enable), .core_powered(core_powered),
		.quarter_bandwidth(quarter_bandwidth));
	adc_host_end adc_host_end_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .link(link.host));
	adc_link_chk adc_link_chk_inst (.aclk(aclk), .aresetn(aresetn), .conversion_start(link.conversion_start),
		.sck(link.sck), .din(link.din), .sdo(link.sdo));

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	// Slot seen on the first cycle only; the mux moves on the same edge that power drops
	always @(posedge aclk) begin
		cap_on <= core_powered;
		if (core_powered && !cap_on) begin
			cap_pos <= mux_pos;
			cap_neg <= mux_neg;
			cap_temp <= temp_select;
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	function automatic int slots(cfg_word_type c);
		return (c[11] ? int'(c[9:7]) + 1 : int'(c[9:8]) + 1) + int'(c[2:1] == 2'h2);
	endfunction

	task automatic conv(input logic [31:0] cmd);
		int n;
		int b;
		logic t;
		@(posedge aclk);
		sample_code <= 16'($urandom);
		temp_code <= 16'($urandom);
		wr(`REG_COMMAND, cmd);
		do rd(`REG_STATUS); while (d[0] !== 1'b0);
		n = slots(act);
		t = k == n - 1 && act[2:1] == 2'h2;
		// Sequencer off holds the last channel or its pair
		b = act[2] ? k : act[11] ? int'(act[9:7]) : int'(act[9:8]);
		if (val) begin
			check(32'(cap_temp), 32'(t));
			if (!t) check(32'(cap_pos), act[11] ? b : 2 * b);
			if (!t) check(32'(cap_neg), act[11] ? b : 2 * b + 1);
			rd(`REG_RESULT);
			check(d, 32'(t ? temp_code : (!act[12] && !(act[11] && act[10])) ?
				sample_code ^ 16'h8000 : sample_code));
		end
		if (arr_v && arr[13]) begin
			if (val && arr[2:1] == 2'h1 && arr[11] == act[11] && arr[9:7] == act[9:7]) begin
				k = (k + 1) % n;
				act = {arr[13:3], act[2:1], arr[0]};
			end else begin
				k = 0;
				act = (arr[2:1] == 2'h1) ? {arr[13:3], act[2:1], arr[0]} : arr;
				val = 1'b1;
			end
		end else if (val) begin
			k = (k + 1) % n;
		end
		arr_v = cmd[1];
		arr = cfg_reg;
		if (val) begin
			check(32'(pair_mode), 32'(!act[11]));
			check(32'(ref_enable), 32'(!act[5]));
			check(32'(buffer_enable), 32'(act[5] ? act[4] : !act[4]));
			check(32'(temp_sensor_enable), 32'(!act[5]));
			check(32'(quarter_bandwidth), 32'(!act[6]));
			check(32'(core_powered), 32'h0000_0000);
		end
	endtask

	task automatic setcfg(input cfg_word_type c, input int extra);
		cfg_reg = c;
		wr(`REG_CONFIG, 32'(c));
		check({30'h0, r}, {30'h0, `AXI_OKAY});
		conv(3);
		repeat (extra) conv(1);
	endtask

	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge aclk);
		fail_count++;
		print_verdict();
	end

	initial begin
		{awvalid, wvalid, bready, arvalid, rready, arr_v, val} = '0;
		{awaddr, araddr, wdata, sample_code, temp_code, k} = '0;
		wstrb = 4'hf;
		aresetn = 1'b0;
		void'($urandom(61));
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		// Start during power-up must be ignored
		wr(`REG_COMMAND, 32'h0000_0001);
		rd(`REG_CONFIG);
		check(d, 32'h0000_3fff);
		rd(8'h10);
		check(d, 32'h0000_0000);
		check({30'h0, r}, {30'h0, `AXI_SLVERR});
		wr(8'h10, 32'h0000_0000);
		check({30'h0, r}, {30'h0, `AXI_SLVERR});
		$display("Register test done");
		do rd(`REG_STATUS); while (d[1] !== 1'b1);
		check(32'(configured), 32'h0000_0000);
		conv(4);
		conv(1);
		conv(1);
		check(32'({pair_mode, ref_enable, buffer_enable, temp_sensor_enable, configured}),
			32'h0000_0005);
		$display("Default load test done");
		setcfg(14'h3fc5, 12);
		$display("Single scan test done");
		setcfg(14'h3f93, 4);
		setcfg(14'($urandom) & 14'h1fff, 3);
		$display("Update test done");
		setcfg(14'h26f7, 6);
		$display("Pair scan test done");
		setcfg(14'h25f3, 4);
		setcfg(14'h3ee1, 3);
		$display("Restart and idle test done");
		print_verdict();
	end
endmodule
